// ===== inc/wtru_pkg.sv
// package: register map, field positions, reset values and timing counts
package wtru_pkg;
	localparam int unsigned CLK_PERIOD_NS  = 100;       // 10 MHz system clock
	localparam int unsigned ADDR_W         = 8;         // byte address width
	localparam logic [7:0]  OFS_CTRL       = 8'h00;     // watchdog_control
	localparam logic [7:0]  OFS_CFG        = 8'h04;     // interval config
	localparam logic [7:0]  OFS_IEN        = 8'h08;     // extended irq enable
	localparam logic [7:0]  OFS_GIE        = 8'h0c;     // global irq enable
	localparam logic [7:0]  OFS_STAT       = 8'h10;     // sticky events, w1c
	localparam logic [7:0]  OFS_MASK       = 8'h14;     // event mask
	localparam int unsigned CTRL_RUN_BIT   = 7;         // timer running
	localparam int unsigned CTRL_TOUT_BIT  = 3;         // timeout_flag
	localparam int unsigned CTRL_CAUSE_BIT = 2;         // reset_cause_flag
	localparam int unsigned CTRL_RSTEN_BIT = 1;         // reset_path_enable
	localparam int unsigned CTRL_RSTRT_BIT = 0;         // restart_strobe
	localparam int unsigned CFG_SEL_LO     = 6;         // interval select 7:6
	localparam int unsigned IEN_WD_BIT     = 5;         // watchdog irq enable
	localparam int unsigned GIE_BIT        = 7;         // global irq enable
	localparam int unsigned ST_TOUT_BIT    = 0;         // timeout event
	localparam int unsigned ST_WDRST_BIT   = 1;         // watchdog reset event
	localparam logic [1:0]  SEL_RST        = 2'h0;      // shortest interval
	localparam logic [7:0]  IEN_RST        = 8'h00;
	localparam logic [1:0]  STAT_RST       = 2'h0;
	localparam logic [1:0]  MASK_RST       = 2'h0;
	localparam int unsigned CNT_W          = 22;        // divider chain width
	localparam logic [21:0] TOUT0_CLKS     = 22'h001000; // 2^12 clocks
	localparam logic [9:0]  POST_TOUT_CLKS = 10'h200;   // grace after timeout
	localparam int unsigned MACH_CYC_CLKS  = 4;         // clocks per machine cyc
	localparam logic [3:0]  RST_HOLD_CLKS  = 4'(2 * MACH_CYC_CLKS);
	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;
	typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_HOLD} wtru_rst_state_t;
endpackage

// ===== inc/wtru_tmr_if.sv
// interface: control and event signals between the top and its timer parts
interface wtru_tmr_if;
	logic       clr;    // restart the chain and cancel a pending reset
	logic       run;    // timer enabled
	logic [1:0] sel;    // interval select
	logic       rst_en; // reset path enable
	logic       tout;   // one-cycle timeout pulse
	logic       fire;   // first cycle of a watchdog reset
	logic       hold;   // watchdog reset active
	modport ctl (output clr, run, sel, rst_en, input tout, fire, hold);
	modport div (input clr, run, sel, output tout);
	modport rst (input clr, tout, rst_en, output fire, hold);
endinterface

// ===== verilog/wtru_div_chain.sv
// module: divider chain with selectable timeout tap
module wtru_div_chain #(
	parameter int unsigned TOUT1_CLKS = 32768,
	parameter int unsigned TOUT2_CLKS = 262144,
	parameter int unsigned TOUT3_CLKS = 2097152
) (
	input  wire logic clk_sys_in,
	input  wire logic srst_in,
	wtru_tmr_if.div   tmr
);
	import wtru_pkg::*;
	logic [CNT_W-1:0] cnt;   // clocks since last restart or tap
	logic [CNT_W-1:0] limit; // selected interval

	// interval select to tap length [R3]
	always_comb begin
		case (tmr.sel)
			2'h0: limit = TOUT0_CLKS;
			2'h1: limit = CNT_W'(TOUT1_CLKS);
			2'h2: limit = CNT_W'(TOUT2_CLKS);
			default: limit = CNT_W'(TOUT3_CLKS);
		endcase
	end

	// counting chain; reset enable is not seen here, so only run low, restart or reset stop it [R1] [R16]
	always_ff @(posedge clk_sys_in) begin
		if (srst_in || tmr.clr || !tmr.run) begin
			cnt <= '0; // restart from a known state [R2]
		end else if (cnt >= limit - 1'b1) begin
			// >= so a shorter select written mid-count wraps at once
			cnt <= '0; // free-running wrap each interval [R10]
		end else begin
			cnt <= cnt + 1'b1;
		end
	end

	// timeout pulse registered so it is glitch free
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			tmr.tout <= 1'b0;
		end else begin
			tmr.tout <= tmr.run && !tmr.clr && (cnt >= limit - 1'b1);
		end
	end

	restart_zero_a: assert property (@(posedge clk_sys_in) // [R2]
		disable iff (srst_in) tmr.clr |=> (cnt == '0) && !tmr.tout)
		else $error("restart did not clear the chain");
endmodule // wtru_div_chain

// ===== verilog/wtru_rst_gen.sv
// module: post-timeout grace counter and watchdog reset pulse
module wtru_rst_gen (
	input  wire logic clk_sys_in,
	input  wire logic srst_in,
	wtru_tmr_if.rst   tmr
);
	import wtru_pkg::*;
	wtru_rst_state_t state;  // idle, grace wait, reset hold
	logic [8:0]      wcnt;   // grace clocks elapsed
	logic [2:0]      hcnt;   // hold clocks elapsed

	// grace window then reset hold
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			state <= ST_IDLE;
			wcnt  <= '0;
			hcnt  <= '0;
		end else begin
			case (state)
				ST_IDLE: begin
					wcnt <= '0;
					hcnt <= '0;
					if (tmr.tout && !tmr.clr) begin
						state <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					if (tmr.clr) begin
						state <= ST_IDLE; // restart cancels [R19] [R6]
					end else if (wcnt == 9'(POST_TOUT_CLKS - 1'b1)) begin
						wcnt  <= '0;
						// reset only when the path is enabled [R5] [R9]
						state <= tmr.rst_en ? ST_HOLD : ST_IDLE;
					end else begin
						wcnt <= wcnt + 1'b1;
					end
				end
				ST_HOLD: begin
					// a restart cannot shorten the reset pulse
					if (hcnt == 3'(RST_HOLD_CLKS - 1'b1)) begin
						state <= ST_IDLE; // two machine cycles [R7]
					end else begin
						hcnt <= hcnt + 1'b1;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	assign tmr.hold = (state == ST_HOLD);
	assign tmr.fire = (state == ST_HOLD) && (hcnt == '0);

	grace_len_a: assert property (@(posedge clk_sys_in) // [R5]
		disable iff (srst_in)
		$rose(tmr.hold) |-> $past(wcnt) == 9'h1ff && $past(tmr.rst_en))
		else $error("reset fired before the grace window ended");
	hold_len_a: assert property (@(posedge clk_sys_in) // [R7]
		disable iff (srst_in) $rose(tmr.hold) |-> tmr.hold[*8] ##1 !tmr.hold)
		else $error("watchdog reset pulse length wrong");
	restart_cancel_a: assert property (@(posedge clk_sys_in) // [R19]
		disable iff (srst_in)
		(state == ST_WAIT && tmr.clr) |=> state == ST_IDLE ##1 !tmr.hold)
		else $error("restart did not cancel pending reset");
endmodule // wtru_rst_gen

// ===== verilog/wtru_top.sv
// module: watchdog timeout/reset unit with an axi4-lite register slave
// Overview of operation
// R1: count derived from clock through divider chain
// R2: restart write clears count, bit self-clears
// R3: select 00..11 gives 2^12/15/18/21 clocks
// R4: elapsed interval sets timeout flag
// R5: reset after 512 more clocks without restart
// R6: software restarts within 512 clocks of timeout
// R7: watchdog reset held two machine cycles, flag set
// R8: irq needs flag, watchdog and global enables
// R9: interrupt and reset paths work independently
// R10: without enables timer runs freely, re-flags
// R11: power-on or power-fail reset disables watchdog
// R12: watchdog reset keeps it enabled, restarts count
// R13: timeout flag cleared by software or reset
// R14: cause flag sticky; software or power-fail clears
// R15: disabled reset path never touches cause flag
// R16: reset enable low does not stop counting
// R17: interval select resets to shortest period
// R18: software restarts before relying on the watchdog
// R19: restart also cancels pending watchdog reset
module wtru_top #(
	parameter int unsigned TOUT1_CLKS = 32768,   // 2^15 clocks
	parameter int unsigned TOUT2_CLKS = 262144,  // 2^18 clocks
	parameter int unsigned TOUT3_CLKS = 2097152  // 2^21 clocks
) (
	input  wire logic                      clk_sys_in,
	input  wire logic                      srst_in,
	input  wire logic                      pwr_fail_in,
	input  wire logic [wtru_pkg::ADDR_W-1:0] awaddr_in,
	input  wire logic                      awvalid_in,
	output logic                           awready_out,
	input  wire logic [31:0]               wdata_in,
	input  wire logic [3:0]                wstrb_in,
	input  wire logic                      wvalid_in,
	output logic                           wready_out,
	output logic [1:0]                     bresp_out,
	output logic                           bvalid_out,
	input  wire logic                      bready_in,
	input  wire logic [wtru_pkg::ADDR_W-1:0] araddr_in,
	input  wire logic                      arvalid_in,
	output logic                           arready_out,
	output logic [31:0]                    rdata_out,
	output logic [1:0]                     rresp_out,
	output logic                           rvalid_out,
	input  wire logic                      rready_in,
	output logic                           irq_out,
	output logic                           wd_irq_out,
	output logic                           sys_rst_out
);
	import wtru_pkg::*;

	// bus capture state
	logic              aw_held;      // write address taken
	logic              w_held;       // write data taken
	logic [ADDR_W-1:0] aw_addr;      // captured write address
	logic [7:0]        w_byte;       // captured low data byte
	logic              w_lane0;      // low byte lane enabled
	logic              wr_go;        // register write this cycle
	logic              wr_hit;       // write address decoded
	logic              rd_hit;       // read address decoded
	logic [7:0]        rd_val;       // read mux result

	// control and status state
	logic       run;                 // watchdog enabled
	logic       timeout_flag;        // interval elapsed
	logic       reset_cause_flag;    // last reset came from watchdog
	logic       reset_path_enable;   // watchdog may reset the system
	logic [1:0] interval_sel;        // hi and lo select bits
	logic [7:0] extended_irq_enable_reg;
	logic       global_irq_enable;
	logic [1:0] irq_status;          // sticky events
	logic [1:0] irq_mask;            // event gate
	logic       restart_strobe;      // one-cycle restart pulse

	// power-fail pin synchroniser
	logic       pf_meta;             // first stage, read by pf_sync only
	logic       pf_sync;             // safe level

	// decoded write strobes
	logic       wr_ctrl;
	logic       wr_cfg;
	logic       wr_ien;
	logic       wr_gie;
	logic       wr_stat;
	logic       wr_mask;

	wtru_tmr_if tmr ();

	// two flops before the pin reaches any logic
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			pf_meta <= 1'b0;
			pf_sync <= 1'b0;
		end else begin
			pf_meta <= pwr_fail_in;
			pf_sync <= pf_meta;
		end
	end

	// write channel capture; address and data may come in either order
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= '0;
			w_byte  <= '0;
			w_lane0 <= 1'b0;
		end else begin
			if (awvalid_in && awready_out) begin
				aw_held <= 1'b1;
				aw_addr <= awaddr_in;
			end else if (wr_go) begin
				aw_held <= 1'b0;
			end
			if (wvalid_in && wready_out) begin
				w_held  <= 1'b1;
				w_byte  <= wdata_in[7:0];
				w_lane0 <= wstrb_in[0];
			end else if (wr_go) begin
				w_held <= 1'b0;
			end
		end
	end

	// ready while the holding slot is empty
	assign awready_out = !aw_held;
	assign wready_out  = !w_held;
	// one write in flight: wait for the response to be taken
	assign wr_go       = aw_held && w_held && !bvalid_out;

	// write address decode
	always_comb begin
		wr_ctrl = 1'b0;
		wr_cfg  = 1'b0;
		wr_ien  = 1'b0;
		wr_gie  = 1'b0;
		wr_stat = 1'b0;
		wr_mask = 1'b0;
		wr_hit  = 1'b1;
		if (aw_addr == OFS_CTRL) begin
			wr_ctrl = wr_go && w_lane0;
		end else if (aw_addr == OFS_CFG) begin
			wr_cfg = wr_go && w_lane0;
		end else if (aw_addr == OFS_IEN) begin
			wr_ien = wr_go && w_lane0;
		end else if (aw_addr == OFS_GIE) begin
			wr_gie = wr_go && w_lane0;
		end else if (aw_addr == OFS_STAT) begin
			wr_stat = wr_go && w_lane0;
		end else if (aw_addr == OFS_MASK) begin
			wr_mask = wr_go && w_lane0;
		end else begin
			wr_hit = 1'b0; // unmapped: slverr, nothing stored
		end
	end

	// write response
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			bvalid_out <= 1'b0;
			bresp_out  <= RESP_OKAY;
		end else if (wr_go) begin
			bvalid_out <= 1'b1;
			bresp_out  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (bready_in) begin
			bvalid_out <= 1'b0;
		end
	end

	// self-clearing restart: a pulse, never stored, reads as zero [R2]
	assign restart_strobe = wr_ctrl && w_byte[CTRL_RSTRT_BIT];

	// run bit: power-on and power-fail disable, watchdog reset keeps it
	always_ff @(posedge clk_sys_in) begin
		if (srst_in || pf_sync) begin
			run <= 1'b0; // [R11]
		end else if (wr_ctrl) begin
			run <= w_byte[CTRL_RUN_BIT]; // hold leaves run alone [R12]
		end
	end

	// reset path enable and interval select
	always_ff @(posedge clk_sys_in) begin
		if (srst_in || pf_sync) begin
			reset_path_enable <= 1'b0;
			interval_sel      <= SEL_RST; // shortest period [R17]
		end else begin
			if (wr_ctrl) begin
				reset_path_enable <= w_byte[CTRL_RSTEN_BIT];
			end
			if (wr_cfg) begin
				interval_sel <= w_byte[CFG_SEL_LO +: 2];
			end
		end
	end

	// timeout flag: any reset clears, hardware set beats software clear
	always_ff @(posedge clk_sys_in) begin
		if (srst_in || pf_sync || tmr.hold) begin
			timeout_flag <= 1'b0; // [R13]
		end else if (tmr.tout) begin
			timeout_flag <= 1'b1; // [R4] [R10]
		end else if (wr_ctrl && !w_byte[CTRL_TOUT_BIT]) begin
			timeout_flag <= 1'b0; // [R13]
		end
	end

	// cause flag: only power-on reset, power-fail or software clear it
	always_ff @(posedge clk_sys_in) begin
		if (srst_in || pf_sync) begin
			reset_cause_flag <= 1'b0; // [R14]
		end else if (tmr.fire) begin
			// fire only exists when the path was enabled [R7] [R15]
			reset_cause_flag <= 1'b1;
		end else if (wr_ctrl && !w_byte[CTRL_CAUSE_BIT]) begin
			reset_cause_flag <= 1'b0; // [R14]
		end
	end

	// interrupt enables, untouched by the watchdog itself
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			extended_irq_enable_reg <= IEN_RST;
			global_irq_enable       <= 1'b0;
			irq_mask                <= MASK_RST;
		end else begin
			if (wr_ien) begin
				extended_irq_enable_reg <= w_byte;
			end
			if (wr_gie) begin
				global_irq_enable <= w_byte[GIE_BIT];
			end
			if (wr_mask) begin
				irq_mask <= w_byte[1:0];
			end
		end
	end

	// sticky event bits, write one to clear; a same-cycle event wins
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			irq_status <= STAT_RST;
		end else begin
			irq_status <= (irq_status & ~(wr_stat ? w_byte[1:0] : 2'h0))
				| {tmr.fire, tmr.tout};
		end
	end

	// feed the timer parts
	assign tmr.run    = run;
	assign tmr.sel    = interval_sel;
	assign tmr.rst_en = reset_path_enable;
	// power-fail and watchdog reset also restart the chain [R12]
	assign tmr.clr    = restart_strobe || pf_sync || tmr.hold; // [R2]

	wtru_div_chain #(
		.TOUT1_CLKS (TOUT1_CLKS),
		.TOUT2_CLKS (TOUT2_CLKS),
		.TOUT3_CLKS (TOUT3_CLKS)
	) u_div (
		.clk_sys_in (clk_sys_in),
		.srst_in    (srst_in),
		.tmr        (tmr.div)
	);

	wtru_rst_gen u_rst (
		.clk_sys_in (clk_sys_in),
		.srst_in    (srst_in),
		.tmr        (tmr.rst)
	);

	// reset output follows the hold state of the generator [R7]
	assign sys_rst_out = tmr.hold;
	// request path independent of the reset path [R8] [R9]
	assign wd_irq_out  = timeout_flag && global_irq_enable
		&& extended_irq_enable_reg[IEN_WD_BIT];
	// summary interrupt from sticky status
	assign irq_out     = |(irq_status & irq_mask);

	// read mux; reserved bits read as zero
	always_comb begin
		rd_val = 8'h00;
		rd_hit = 1'b1;
		if (araddr_in == OFS_CTRL) begin
			rd_val[CTRL_RUN_BIT]   = run;
			rd_val[CTRL_TOUT_BIT]  = timeout_flag;
			rd_val[CTRL_CAUSE_BIT] = reset_cause_flag;
			rd_val[CTRL_RSTEN_BIT] = reset_path_enable;
		end else if (araddr_in == OFS_CFG) begin
			rd_val[CFG_SEL_LO +: 2] = interval_sel;
		end else if (araddr_in == OFS_IEN) begin
			rd_val = extended_irq_enable_reg;
		end else if (araddr_in == OFS_GIE) begin
			rd_val[GIE_BIT] = global_irq_enable;
		end else if (araddr_in == OFS_STAT) begin
			rd_val[1:0] = irq_status;
		end else if (araddr_in == OFS_MASK) begin
			rd_val[1:0] = irq_mask;
		end else begin
			rd_hit = 1'b0;
		end
	end

	// read channel: one read in flight, data registered
	assign arready_out = !rvalid_out;
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			rvalid_out <= 1'b0;
			rdata_out  <= '0;
			rresp_out  <= RESP_OKAY;
		end else if (arvalid_in && arready_out) begin
			rvalid_out <= 1'b1;
			rdata_out  <= {24'h000000, rd_val};
			rresp_out  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (rready_in) begin
			rvalid_out <= 1'b0;
		end
	end

	tout_flag_a: assert property (@(posedge clk_sys_in) // [R4]
		disable iff (srst_in)
		(tmr.tout && !pf_sync && !tmr.hold) |=> timeout_flag)
		else $error("timeout pulse did not set the flag");
	irq_gate_a: assert property (@(posedge clk_sys_in) // [R8]
		disable iff (srst_in)
		(!global_irq_enable || !timeout_flag
			|| !extended_irq_enable_reg[IEN_WD_BIT]) |-> !wd_irq_out)
		else $error("watchdog irq without flag and enables");
	cause_set_a: assert property (@(posedge clk_sys_in) // [R7]
		disable iff (srst_in)
		$rose(sys_rst_out) && !pf_sync |=> reset_cause_flag)
		else $error("watchdog reset did not set cause flag");
	cause_guard_a: assert property (@(posedge clk_sys_in) // [R15]
		disable iff (srst_in)
		$rose(reset_cause_flag) |-> $past(reset_path_enable, 2))
		else $error("cause flag set with reset path disabled");
	sel_default_a: assert property (@(posedge clk_sys_in) // [R17]
		disable iff (srst_in) $fell(srst_in) |-> interval_sel == 2'h0)
		else $error("interval select not shortest after reset");
	pwr_fail_a: assert property (@(posedge clk_sys_in) // [R11]
		disable iff (srst_in)
		pf_sync |=> !run && !reset_cause_flag && !timeout_flag)
		else $error("power-fail did not disable the watchdog");
	keep_run_a: assert property (@(posedge clk_sys_in) // [R12]
		disable iff (srst_in)
		($rose(sys_rst_out) && run && !pf_sync && !wr_ctrl) |=> run)
		else $error("watchdog reset disabled the watchdog");
	tout_cov_c: cover property (@(posedge clk_sys_in)
		disable iff (srst_in) $rose(timeout_flag));
	wdrst_cov_c: cover property (@(posedge clk_sys_in)
		disable iff (srst_in) $rose(sys_rst_out));
	irq_cov_c: cover property (@(posedge clk_sys_in)
		disable iff (srst_in) wd_irq_out && irq_out);
endmodule // wtru_top

// ===== sim/test_watchdog_timeout_reset_unit.sv
// testbench: drives the watchdog unit over axi4-lite and checks its pins
module test_watchdog_timeout_reset_unit;
	timeunit 1ns;
	timeprecision 1ns;
	import wtru_pkg::*;
	// shortened intervals keep the run well under the cycle budget
	localparam int unsigned T1 = 64;
	localparam int unsigned T2 = 128;
	localparam int unsigned T3 = 256;
	typedef struct packed {
		logic [7:0]  a;  // byte address
		logic [7:0]  d;  // write data
		logic [31:0] e;  // expected read data
		logic [1:0]  r;  // expected response
	} wtru_tb_row_t;
	logic        clk_sys  = 1'b0;   // system clock
	logic        srst     = 1'b1;   // power-on reset, held at start
	logic        pwr_fail = 1'b0;   // power-fail pin
	logic [7:0]  awaddr   = 8'h00;
	logic        awvalid  = 1'b0;
	logic [31:0] wdata    = 32'h0;
	logic        wvalid   = 1'b0;
	logic        bready   = 1'b0;
	logic [7:0]  araddr   = 8'h00;
	logic        arvalid  = 1'b0;
	logic        rready   = 1'b0;
	wire         awready, wready, bvalid, arready, rvalid;
	wire  [1:0]  bresp, rresp;
	wire  [31:0] rdata;
	wire         irq, wd_irq, sys_rst;
	int          failures = 0;      // mismatches seen
	int          compares = 0;      // checks made
	int unsigned lens[4] = '{32'd4096, T1, T2, T3};
	wtru_tb_row_t rows[7] = '{
		'{OFS_CFG,  8'hc0, 32'hc0, RESP_OKAY},
		'{OFS_IEN,  8'h20, 32'h20, RESP_OKAY},
		'{OFS_GIE,  8'h80, 32'h80, RESP_OKAY},
		'{OFS_MASK, 8'h03, 32'h03, RESP_OKAY},
		'{OFS_CTRL, 8'h02, 32'h02, RESP_OKAY},
		'{OFS_CTRL, 8'h01, 32'h00, RESP_OKAY},
		'{8'h18,    8'hff, 32'h00, RESP_SLVERR}};

	// free-running system clock
	always #(CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;

	wtru_top #(.TOUT1_CLKS(T1), .TOUT2_CLKS(T2), .TOUT3_CLKS(T3)) u_wtru_top (
		.clk_sys_in(clk_sys), .srst_in(srst), .pwr_fail_in(pwr_fail),
		.awaddr_in(awaddr), .awvalid_in(awvalid), .awready_out(awready),
		.wdata_in(wdata), .wstrb_in(4'h1), .wvalid_in(wvalid),
		.wready_out(wready), .bresp_out(bresp), .bvalid_out(bvalid),
		.bready_in(bready), .araddr_in(araddr), .arvalid_in(arvalid),
		.arready_out(arready), .rdata_out(rdata), .rresp_out(rresp),
		.rvalid_out(rvalid), .rready_in(rready), .irq_out(irq),
		.wd_irq_out(wd_irq), .sys_rst_out(sys_rst));

	// verdict in one place
	task automatic wrap_up();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("BAD at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// a bounded wait ran out: count it and stop
	task automatic hang();
		chk(32'h0, 32'h1);
		wrap_up();
	endtask

	// one write; address and data offered together, each released when taken
	task automatic axw(input logic [7:0] a, input logic [7:0] d,
		output logic [1:0] r);
		int   n;
		logic done;
		done = 1'b0;
		r = 2'h3;
		@(posedge clk_sys);
		awaddr  <= a;
		awvalid <= 1'b1;
		wdata   <= {24'h0, d};
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		for (n = 0; n < 64 && !done; n++) begin
			@(posedge clk_sys);
			if (awvalid && awready === 1'b1) awvalid <= 1'b0;
			if (wvalid && wready === 1'b1) wvalid <= 1'b0;
			if (bvalid === 1'b1) begin
				r = bresp;
				bready <= 1'b0;
				done = 1'b1;
			end
		end
		if (!done) hang();
	endtask

	// one read; rready held until the data is sampled
	task automatic axr(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		int   n;
		logic done;
		done = 1'b0;
		d = 32'h0;
		r = 2'h3;
		@(posedge clk_sys);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		for (n = 0; n < 64 && !done; n++) begin
			@(posedge clk_sys);
			if (arvalid && arready === 1'b1) arvalid <= 1'b0;
			if (rvalid === 1'b1) begin
				d = rdata;
				r = rresp;
				rready <= 1'b0;
				done = 1'b1;
			end
		end
		if (!done) hang();
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [1:0] r;
		axw(a, d, r);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0]  r;
		axr(a, d, r);
		chk(d, e);
	endtask

	// counts edges until wd_irq (which=0) or sys_rst (which=1) is seen high
	task automatic wait_for(input bit which, input int lim, output int cyc,
		output logic hit);
		hit = 1'b0;
		cyc = 0;
		while (cyc < lim && !hit) begin
			@(posedge clk_sys);
			cyc++;
			hit = ((which ? sys_rst : wd_irq) === 1'b1);
		end
	endtask

	// main sequence
	initial begin
		int          i;
		int          cyc;
		logic        hit;
		logic [31:0] d;
		logic [1:0]  r;
		repeat (3) @(posedge clk_sys);
		srst <= 1'b0;
		// register access table, unmapped address included
		for (i = 0; i < 7; i++) begin
			axw(rows[i].a, rows[i].d, r);
			chk(r, rows[i].r);
			axr(rows[i].a, d, r);
			chk(d, rows[i].e);
			chk(r, rows[i].r);
		end
		// every interval select, timed from the restart
		for (i = 0; i < 4; i++) begin
			wr(OFS_CFG, {i[1:0], 6'h0});
			wr(OFS_CTRL, 8'h81);
			wait_for(0, lens[i] + 10, cyc, hit);
			chk(32'(hit && cyc + 3 >= lens[i] && cyc <= lens[i] + 3), 1);
		end
		// reset path off: no reset, no cause flag, counter keeps going
		wait_for(1, 700, cyc, hit);
		chk(32'(hit), 0);
		rd(OFS_CTRL, 32'h88);
		chk(32'(wd_irq), 1);
		wr(OFS_GIE, 8'h00);
		chk(32'(wd_irq), 0);
		wr(OFS_GIE, 8'h80);
		wr(OFS_CTRL, 8'h80);
		wait_for(0, T3 + 10, cyc, hit);
		chk(32'(hit), 1);
		// restart in mid-grace cancels the pending reset
		wr(OFS_CFG, 8'h40);
		wr(OFS_CTRL, 8'h83);
		wait_for(0, T1 + 10, cyc, hit);
		repeat (300) @(posedge clk_sys);
		wr(OFS_CTRL, 8'h83);
		wait_for(1, 400, cyc, hit);
		chk(32'(hit), 0);
		// no restart: reset after the grace period, held two machine cycles
		wr(OFS_CTRL, 8'h83);
		wait_for(0, T1 + 10, cyc, hit);
		wait_for(1, 600, cyc, hit);
		chk(32'(hit && cyc >= 509 && cyc <= 515), 1);
		cyc = 0;
		while (sys_rst === 1'b1 && cyc < 20) begin
			@(posedge clk_sys);
			cyc++;
		end
		chk(cyc, 2 * MACH_CYC_CLKS);
		rd(OFS_CTRL, 32'h86);
		rd(OFS_STAT, 32'h03);
		// power-fail stops the timer and clears the cause flag
		@(posedge clk_sys);
		pwr_fail <= 1'b1;
		repeat (4) @(posedge clk_sys);
		pwr_fail <= 1'b0;
		repeat (4) @(posedge clk_sys);
		rd(OFS_CTRL, 32'h00);
		rd(OFS_CFG, 32'h00);
		// summary interrupt: raised, masked, cleared
		chk(32'(irq), 1);
		wr(OFS_MASK, 8'h00);
		chk(32'(irq), 0);
		wr(OFS_MASK, 8'h03);
		wr(OFS_STAT, 8'h03);
		rd(OFS_STAT, 32'h00);
		chk(32'(irq), 0);
		// mid-run reset returns every register to zero
		wr(OFS_CTRL, 8'h81);
		wr(OFS_CFG, 8'hc0);
		// let the flag set so the reset below really has to clear it
		wait_for(0, T3 + 10, cyc, hit);
		chk(32'(hit), 1);
		srst <= 1'b1;
		repeat (3) @(posedge clk_sys);
		srst <= 1'b0;
		for (i = 0; i < 6; i++) begin
			rd(8'(4 * i), 32'h0);
		end
		wrap_up();
	end
endmodule // test_watchdog_timeout_reset_unit
